// File: hdl/lvrc_top.sv
`timescale 1ns/10ps
module lvrc_top (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic [7:0] i_paddr,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_por_detect,
   input wire logic i_below_low_thresh,
   input wire logic i_below_high_thresh,
   input wire logic i_below_warn_thresh,
   input wire lvrc_pkg::lvrc_src_type i_src,
   input wire logic [lvrc_pkg::vector_count-1:1] i_irq_pending,
   input wire logic i_stop_req,
   input wire logic i_stop2_sel,
   output logic o_system_reset,
   output logic [1:0] o_stop_mode,
   output logic o_detector_active,
   output logic o_low_volt_warning_flag,
   output logic o_vector_valid,
   output logic [2:0] o_vector_num,
   output logic [15:0] o_vector_addr
);
   logic [6:0] ctl_q;
   logic [6:0] ctl_d;
   logic [7:0] status_q;
   logic [7:0] status_d;
   logic hold_q;
   logic hold_d;
   logic rst_q;
   logic [1:0] mode_q;
   logic [1:0] mode_d;
   logic warn_q;
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;
   logic pready_q;
   logic pslverr_q;
   logic vec_valid_q;
   logic [2:0] vec_num_q;
   logic [15:0] vec_addr_q;
   logic por_seen_q;

   wire logic detector_enable = ctl_q[lvrc_pkg::ctl_detector_enable_bit];
   wire logic detector_stop_enable =
      ctl_q[lvrc_pkg::ctl_detector_stop_enable_bit];
   wire logic low_volt_reset_enable =
      ctl_q[lvrc_pkg::ctl_low_volt_reset_enable_bit];
   wire logic threshold_select = ctl_q[lvrc_pkg::ctl_threshold_select_bit];
   wire logic watchdog_enable = ctl_q[lvrc_pkg::ctl_watchdog_enable_bit];
   wire logic clock_monitor_enable =
      ctl_q[lvrc_pkg::ctl_clock_monitor_enable_bit];

   // Detector state
   wire logic in_stop = (mode_q != lvrc_pkg::lvrc_run_mode);
   wire logic det_on = detector_enable
      && (!in_stop || detector_stop_enable);
   wire logic sel_below = threshold_select
      ? i_below_high_thresh : i_below_low_thresh;
   wire logic lv_detect = det_on && sel_below;
   wire logic lv_reset = lv_detect && low_volt_reset_enable;

   // Gated and ungated sources
   wire logic wd_reset = i_src.watchdog && watchdog_enable;
   wire logic cl_reset = i_src.clock_loss && clock_monitor_enable;
   wire logic other_reset = i_src.pin || i_src.bad_opcode
      || i_src.bad_address || i_src.debug_forced;
   wire logic any_src = i_por_detect || lv_reset || wd_reset || cl_reset
      || other_reset;

   // Hold: POR waits for low threshold, low volt waits for selected one
   wire logic hold_por = por_seen_q && i_below_low_thresh;
   wire logic hold_lv = hold_q && !por_seen_q && sel_below;
   assign hold_d = any_src || hold_por || hold_lv;

   // Stop mode request resolution
   always_comb begin
      mode_d = mode_q;
      if (i_stop_req) begin
         if (i_stop2_sel && !(detector_enable && detector_stop_enable)) begin
            mode_d = lvrc_pkg::lvrc_stop2_mode;
         end else begin
            mode_d = lvrc_pkg::lvrc_stop3_mode;
         end
      end else if (any_src) begin
         mode_d = lvrc_pkg::lvrc_run_mode;
      end
   end

   // Cause flags: new reset clears old causes and records new ones
   always_comb begin
      status_d = status_q;
      if (any_src && !hold_q) begin
         status_d = 8'h00;
      end
      if (i_por_detect) begin
         status_d = 8'h00;
         status_d[lvrc_pkg::st_power_on_bit] = 1'b1;
         status_d[lvrc_pkg::st_low_volt_bit] = 1'b1;
      end else if (any_src) begin
         status_d[lvrc_pkg::st_low_volt_bit] =
            status_d[lvrc_pkg::st_low_volt_bit] | lv_reset;
         status_d[lvrc_pkg::st_watchdog_bit] =
            status_d[lvrc_pkg::st_watchdog_bit] | wd_reset;
         status_d[lvrc_pkg::st_clock_loss_bit] =
            status_d[lvrc_pkg::st_clock_loss_bit] | cl_reset;
         status_d[lvrc_pkg::st_pin_bit] =
            status_d[lvrc_pkg::st_pin_bit] | i_src.pin;
         status_d[lvrc_pkg::st_bad_opcode_bit] =
            status_d[lvrc_pkg::st_bad_opcode_bit] | i_src.bad_opcode;
         status_d[lvrc_pkg::st_bad_address_bit] =
            status_d[lvrc_pkg::st_bad_address_bit] | i_src.bad_address;
         status_d[lvrc_pkg::st_debug_forced_bit] =
            status_d[lvrc_pkg::st_debug_forced_bit] | i_src.debug_forced;
      end
   end

   // APB: one wait state; writes land on the edge that sees pready
   wire logic apb_acc = i_psel && i_penable && !pready_q;
   wire logic apb_done = i_psel && i_penable && pready_q;
   wire logic apb_wr = apb_done && i_pwrite;
   wire logic hit_ctl = (i_paddr == lvrc_pkg::power_mgmt_control_1_off);
   wire logic hit_st = (i_paddr == lvrc_pkg::reset_status_register_off);
   wire logic hit_src = (i_paddr == lvrc_pkg::reset_source_input_off);
   wire logic hit_mode = (i_paddr == lvrc_pkg::stop_request_off);
   wire logic hit_vec = (i_paddr == lvrc_pkg::vector_status_off);
   wire logic hit_any = hit_ctl || hit_st || hit_src || hit_mode || hit_vec;

   // Control writes; reset state keeps last setting except on POR
   always_comb begin
      ctl_d = ctl_q;
      if (i_por_detect) begin
         ctl_d = lvrc_pkg::ctl_reset_value;
      end else if (apb_wr && hit_ctl && !o_system_reset) begin
         ctl_d = i_pwdata[6:0];
      end
   end

   always_comb begin
      prdata_d = 32'h0000_0000;
      if (hit_ctl) begin
         prdata_d = {25'h0000000, ctl_q};
      end else if (hit_st) begin
         prdata_d = {24'h000000, status_q};
      end else if (hit_src) begin
         prdata_d = {24'h000000, warn_q, sel_below, det_on, i_por_detect,
            i_src.watchdog, i_src.clock_loss, i_src.pin, i_src.bad_opcode};
      end else if (hit_mode) begin
         prdata_d = {30'h00000000, mode_q};
      end else if (hit_vec) begin
         prdata_d = {8'h00, vec_addr_q, 1'b0, vec_num_q, 3'h0, vec_valid_q};
      end
   end

   // Vector arbitration; reset state pends vector 0
   logic [lvrc_pkg::vector_count-1:0] pend;
   logic arb_valid;
   logic [2:0] arb_num;
   logic [15:0] arb_addr;
   assign pend = {i_irq_pending, hold_q};

   lvrc_vector_arb #(
      .N(lvrc_pkg::vector_count)
   ) u_arb (
      .i_pending(pend),
      .o_valid(arb_valid),
      .o_num(arb_num),
      .o_addr(arb_addr)
   );

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         ctl_q <= lvrc_pkg::ctl_reset_value;
         status_q <= lvrc_pkg::st_reset_value;
         hold_q <= 1'b1;
         rst_q <= 1'b1;
         por_seen_q <= 1'b1;
         mode_q <= lvrc_pkg::lvrc_run_mode;
         warn_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         vec_valid_q <= 1'b0;
         vec_num_q <= 3'h0;
         vec_addr_q <= 16'h0000;
      end else begin
         ctl_q <= ctl_d;
         status_q <= status_d;
         hold_q <= hold_d;
         rst_q <= hold_q;
         por_seen_q <= i_por_detect || (por_seen_q && hold_d);
         mode_q <= mode_d;
         warn_q <= det_on && i_below_warn_thresh;
         prdata_q <= prdata_d;
         pready_q <= apb_acc;
         pslverr_q <= apb_acc && !hit_any;
         vec_valid_q <= arb_valid;
         vec_num_q <= arb_num;
         vec_addr_q <= arb_addr;
      end
   end

   assign o_system_reset = rst_q;
   assign o_prdata = prdata_q;
   assign o_pready = pready_q;
   assign o_pslverr = pslverr_q;
   assign o_stop_mode = mode_q;
   assign o_low_volt_warning_flag = warn_q;
   assign o_vector_valid = vec_valid_q;
   assign o_vector_num = vec_num_q;
   assign o_vector_addr = vec_addr_q;

   logic det_q;
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         det_q <= 1'b0;
      end else begin
         det_q <= det_on;
      end
   end
   assign o_detector_active = det_q;

   property p_por_reset;
      @(posedge i_clk) disable iff (i_reset)
      i_por_detect |-> ##2 o_system_reset;
   endproperty
   a_por_reset: assert property (p_por_reset) else $error("por no reset");

   property p_por_hold;
      @(posedge i_clk) disable iff (i_reset)
      (por_seen_q && i_below_low_thresh) |-> ##2 o_system_reset;
   endproperty
   a_por_hold: assert property (p_por_hold) else $error("por hold");

   property p_por_flags;
      @(posedge i_clk) disable iff (i_reset)
      i_por_detect |=> status_q[lvrc_pkg::st_power_on_bit]
         && status_q[lvrc_pkg::st_low_volt_bit];
   endproperty
   a_por_flags: assert property (p_por_flags) else $error("por flags");

   property p_det_off;
      @(posedge i_clk) disable iff (i_reset)
      !detector_enable |=> !o_detector_active;
   endproperty
   a_det_off: assert property (p_det_off) else $error("det active");

   property p_stop_off;
      @(posedge i_clk) disable iff (i_reset)
      (in_stop && !detector_stop_enable) |=> !o_detector_active;
   endproperty
   a_stop_off: assert property (p_stop_off) else $error("stop det");

   property p_stop3;
      @(posedge i_clk) disable iff (i_reset)
      (i_stop_req && detector_enable && detector_stop_enable)
         |=> o_stop_mode == lvrc_pkg::lvrc_stop3_mode;
   endproperty
   a_stop3: assert property (p_stop3) else $error("stop2 taken");

   property p_lv_gate;
      @(posedge i_clk) disable iff (i_reset)
      (!hold_q && !i_por_detect && !wd_reset && !cl_reset && !other_reset
         && !hold_por && !low_volt_reset_enable) |=> !hold_q;
   endproperty
   a_lv_gate: assert property (p_lv_gate) else $error("lv gate");

   property p_lv_flag;
      @(posedge i_clk) disable iff (i_reset)
      (lv_reset && !i_por_detect) |=> status_q[lvrc_pkg::st_low_volt_bit];
   endproperty
   a_lv_flag: assert property (p_lv_flag) else $error("lv flag");

   property p_vec_reset;
      @(posedge i_clk) disable iff (i_reset)
      hold_q |=> o_vector_num == lvrc_pkg::reset_vector_num
         && o_vector_addr == lvrc_pkg::reset_vector_addr;
   endproperty
   a_vec_reset: assert property (p_vec_reset) else $error("vec");

   property p_release;
      @(posedge i_clk) disable iff (i_reset)
      $fell(hold_q) |=> $fell(o_system_reset);
   endproperty
   a_release: assert property (p_release) else $error("release");

   property p_lv_sel;
      @(posedge i_clk) disable iff (i_reset)
      (det_on && low_volt_reset_enable
         && (threshold_select ? i_below_high_thresh : i_below_low_thresh))
         |=> hold_q;
   endproperty
   a_lv_sel: assert property (p_lv_sel) else $error("lv select");

   property p_lv_hold;
      @(posedge i_clk) disable iff (i_reset)
      (hold_q && !por_seen_q && (threshold_select
         ? i_below_high_thresh : i_below_low_thresh)) |=> hold_q;
   endproperty
   a_lv_hold: assert property (p_lv_hold) else $error("lv hold");

   property p_plain_src;
      @(posedge i_clk) disable iff (i_reset)
      (i_src.pin || i_src.bad_opcode || i_src.bad_address
         || i_src.debug_forced) |=> hold_q;
   endproperty
   a_plain_src: assert property (p_plain_src) else $error("src");

   property p_gated_src;
      @(posedge i_clk) disable iff (i_reset)
      ((i_src.watchdog && watchdog_enable)
         || (i_src.clock_loss && clock_monitor_enable)) |=> hold_q;
   endproperty
   a_gated_src: assert property (p_gated_src) else $error("gated");

   property p_vec_irq;
      @(posedge i_clk) disable iff (i_reset)
      (!hold_q && i_irq_pending[1]) |=> o_vector_num == 3'h1
         && o_vector_addr == lvrc_pkg::reset_vector_addr - 16'h0002;
   endproperty
   a_vec_irq: assert property (p_vec_irq) else $error("vec irq");

   property p_rel_time;
      @(posedge i_clk) disable iff (i_reset)
      (hold_q && !hold_d) |-> ##2 !o_system_reset;
   endproperty
   a_rel_time: assert property (p_rel_time) else $error("late");

   property p_det_keep;
      @(posedge i_clk) disable iff (i_reset)
      (detector_enable && detector_stop_enable) |=> o_detector_active;
   endproperty
   a_det_keep: assert property (p_det_keep) else $error("det off");

   property p_warn_off;
      @(posedge i_clk) disable iff (i_reset)
      !detector_enable |=> !o_low_volt_warning_flag;
   endproperty
   a_warn_off: assert property (p_warn_off) else $error("warn");
endmodule : lvrc_top

// File: hdl/lvrc_pkg.sv
package lvrc_pkg;
   // Register byte offsets
   localparam logic [7:0] power_mgmt_control_1_off = 8'h00;
   localparam logic [7:0] reset_status_register_off = 8'h04;
   localparam logic [7:0] reset_source_input_off = 8'h08;
   localparam logic [7:0] stop_request_off = 8'h0c;
   localparam logic [7:0] vector_status_off = 8'h10;

   // Control register fields
   localparam int ctl_detector_enable_bit = 0;
   localparam int ctl_detector_stop_enable_bit = 1;
   localparam int ctl_low_volt_reset_enable_bit = 2;
   localparam int ctl_threshold_select_bit = 3;
   localparam int ctl_watchdog_enable_bit = 4;
   localparam int ctl_clock_monitor_enable_bit = 5;
   localparam int ctl_low_volt_warning_irq_enable_bit = 6;
   localparam logic [6:0] ctl_reset_value = 7'h01;

   // Status register fields
   localparam int st_watchdog_bit = 0;
   localparam int st_clock_loss_bit = 1;
   localparam int st_low_volt_bit = 2;
   localparam int st_pin_bit = 3;
   localparam int st_bad_opcode_bit = 4;
   localparam int st_bad_address_bit = 5;
   localparam int st_power_on_bit = 6;
   localparam int st_debug_forced_bit = 7;
   localparam logic [7:0] st_reset_value = 8'h44;

   localparam logic [15:0] reset_vector_addr = 16'hfffe;
   localparam logic [15:0] vector_table_top = 16'hfffe;
   localparam int vector_count = 7;
   localparam logic [2:0] reset_vector_num = 3'h0;

   // Stop mode codes returned by the block on o_stop_mode
   typedef enum logic [1:0] {
      lvrc_run_mode,
      lvrc_stop2_mode,
      lvrc_stop3_mode
   } lvrc_mode_type;

   typedef struct packed {
      logic watchdog;
      logic clock_loss;
      logic pin;
      logic bad_opcode;
      logic bad_address;
      logic debug_forced;
   } lvrc_src_type;

   typedef struct packed {
      logic [7:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } lvrc_apb_req_type;
endpackage : lvrc_pkg

// File: hdl/lvrc_vector_arb.sv
`timescale 1ns/10ps
// Lowest numbered pending vector wins
module lvrc_vector_arb #(
   parameter int N = 7
) (
   input wire logic [N-1:0] i_pending,
   output logic o_valid,
   output logic [2:0] o_num,
   output logic [15:0] o_addr
);
   function automatic logic [2:0] pick(input logic [N-1:0] p);
      logic [2:0] r;
      r = 3'h0;
      for (int k = N - 1; k >= 0; k--) begin
         if (p[k]) begin
            r = 3'(k);
         end
      end
      return r;
   endfunction : pick

   assign o_valid = |i_pending;
   assign o_num = pick(i_pending);
   assign o_addr = lvrc_pkg::vector_table_top - {12'h000, o_num, 1'b0};
endmodule : lvrc_vector_arb

// File: sim/lvrc_top_tb.sv
`timescale 1ns/10ps
module lvrc_top_tb;
   logic i_clk, i_reset, i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
   logic [7:0] i_paddr;
   logic [31:0] i_pwdata, o_prdata, rd;
   logic i_por_detect, i_below_low_thresh, i_below_high_thresh;
   logic i_below_warn_thresh, i_stop_req, i_stop2_sel;
   lvrc_pkg::lvrc_src_type i_src;
   logic [lvrc_pkg::vector_count-1:1] i_irq_pending;
   logic o_system_reset, o_detector_active, o_low_volt_warning_flag;
   logic o_vector_valid, err;
   logic [1:0] o_stop_mode;
   logic [2:0] o_vector_num;
   logic [15:0] o_vector_addr;
   int n_errors, compares;
   lvrc_top dut (.i_clk(i_clk), .i_reset(i_reset), .i_paddr(i_paddr),
      .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
      .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
      .o_pslverr(o_pslverr), .i_por_detect(i_por_detect),
      .i_below_low_thresh(i_below_low_thresh),
      .i_below_high_thresh(i_below_high_thresh),
      .i_below_warn_thresh(i_below_warn_thresh), .i_src(i_src),
      .i_irq_pending(i_irq_pending), .i_stop_req(i_stop_req),
      .i_stop2_sel(i_stop2_sel), .o_system_reset(o_system_reset),
      .o_stop_mode(o_stop_mode), .o_detector_active(o_detector_active),
      .o_low_volt_warning_flag(o_low_volt_warning_flag),
      .o_vector_valid(o_vector_valid), .o_vector_num(o_vector_num),
      .o_vector_addr(o_vector_addr));
   task automatic conclude();
      $display("Counts: %0d compares, %0d errors", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : conclude
   task automatic chk(input string what, input logic [31:0] exp,
         input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Fixed one wait state, but the loop trusts only pready
   task automatic apb(input logic wr, input logic [7:0] a,
         input logic [31:0] d);
      int k;
      k = 0;
      @(posedge i_clk);
      i_psel <= 1'b1;
      i_pwrite <= wr;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_clk);
      i_penable <= 1'b1;
      do begin
         @(posedge i_clk);
         k++;
         if (k > 20) begin
            chk("pready wait", 1, 0);
            conclude();
         end
      end while (o_pready !== 1'b1);
      rd = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask : apb
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk("read data", e, rd);
   endtask : rchk
   task automatic wait_rst(input logic v, input int bound);
      int k;
      k = 0;
      while (o_system_reset !== v) begin
         @(posedge i_clk);
         k++;
         if (k > bound) begin
            chk("system_reset wait", v, ~v);
            conclude();
         end
      end
   endtask : wait_rst
   task automatic hold(input logic v, input int n);
      repeat (n) begin
         @(posedge i_clk);
         chk("system_reset", v, o_system_reset);
      end
   endtask : hold
   task automatic t_init();
      wait_rst(1'b0, 10);
      rchk(lvrc_pkg::power_mgmt_control_1_off, 32'h01);
      rchk(lvrc_pkg::reset_status_register_off, 32'h44);
      apb(1'b0, 8'h20, 32'h0);
      chk("pslverr", 1, err);
      $display("Test init done");
   endtask : t_init
   task automatic t_por();
      i_below_low_thresh <= 1'b1;
      i_por_detect <= 1'b1;
      wait_rst(1'b1, 5);
      i_por_detect <= 1'b0;
      hold(1'b1, 10);
      chk("vector addr", 16'hfffe, o_vector_addr);
      i_below_low_thresh <= 1'b0;
      wait_rst(1'b0, 6);
      rchk(lvrc_pkg::reset_status_register_off, 32'h44);
      $display("Test por done");
   endtask : t_por
   task automatic t_lv();
      apb(1'b1, lvrc_pkg::power_mgmt_control_1_off, 32'h04);
      i_below_low_thresh <= 1'b1;
      i_below_warn_thresh <= 1'b1;
      hold(1'b0, 8);
      chk("detector active", 0, o_detector_active);
      chk("warning flag", 0, o_low_volt_warning_flag);
      apb(1'b1, lvrc_pkg::power_mgmt_control_1_off, 32'h01);
      hold(1'b0, 8);
      chk("warning flag", 1, o_low_volt_warning_flag);
      chk("detector active", 1, o_detector_active);
      i_below_warn_thresh <= 1'b0;
      i_below_low_thresh <= 1'b0;
      i_below_high_thresh <= 1'b1;
      apb(1'b1, lvrc_pkg::power_mgmt_control_1_off, 32'h05);
      hold(1'b0, 8);
      i_below_low_thresh <= 1'b1;
      wait_rst(1'b1, 5);
      i_below_high_thresh <= 1'b0;
      hold(1'b1, 8);
      i_below_low_thresh <= 1'b0;
      wait_rst(1'b0, 6);
      rchk(lvrc_pkg::reset_status_register_off, 32'h04);
      apb(1'b1, lvrc_pkg::power_mgmt_control_1_off, 32'h0d);
      i_below_high_thresh <= 1'b1;
      wait_rst(1'b1, 5);
      hold(1'b1, 8);
      i_below_high_thresh <= 1'b0;
      wait_rst(1'b0, 6);
      rchk(lvrc_pkg::reset_status_register_off, 32'h04);
      $display("Test lv done");
   endtask : t_lv
   task automatic src_rst(input logic [5:0] s, input int b,
         input logic [31:0] c);
      apb(1'b1, lvrc_pkg::power_mgmt_control_1_off, c);
      i_src <= s;
      wait_rst(1'b1, 5);
      @(posedge i_clk);
      chk("reset vector num", 0, o_vector_num);
      chk("reset vector addr", 16'hfffe, o_vector_addr);
      i_src <= '0;
      wait_rst(1'b0, 6);
      chk("mode after reset", 0, o_stop_mode);
      rchk(lvrc_pkg::reset_status_register_off, 32'h1 << b);
   endtask : src_rst
   task automatic t_stop();
      logic [1:0] m;
      for (int i = 0; i < 2; i++) begin
         apb(1'b1, lvrc_pkg::power_mgmt_control_1_off, i ? 32'h01 : 32'h03);
         i_stop2_sel <= 1'b1;
         i_stop_req <= 1'b1;
         @(posedge i_clk);
         i_stop_req <= 1'b0;
         repeat (3) @(posedge i_clk);
         m = i ? 2'd1 : 2'd2;
         chk("stop mode", m, o_stop_mode);
         rchk(lvrc_pkg::stop_request_off, {30'h0, m});
         chk("detector in stop", i ? 0 : 1, o_detector_active);
         src_rst(6'b001000, lvrc_pkg::st_pin_bit, 32'h01);
      end
      $display("Test stop done");
   endtask : t_stop
   task automatic t_vec();
      i_irq_pending <= 6'b101000;
      repeat (3) @(posedge i_clk);
      chk("vector valid", 1, o_vector_valid);
      chk("vector num", 4, o_vector_num);
      chk("vector addr", 16'hfff6, o_vector_addr);
      i_irq_pending <= 6'b100001;
      repeat (3) @(posedge i_clk);
      chk("vector num", 1, o_vector_num);
      chk("vector addr", 16'hfffc, o_vector_addr);
      rchk(lvrc_pkg::vector_status_off, 32'h00fffc11);
      $display("Test vec done");
   endtask : t_vec
   task automatic t_src();
      int bits [6] = '{0, 1, 3, 4, 5, 7};
      apb(1'b1, lvrc_pkg::power_mgmt_control_1_off, 32'h01);
      i_src <= 6'b110000;
      hold(1'b0, 8);
      i_src <= '0;
      for (int i = 0; i < 6; i++) begin
         src_rst(6'b100000 >> i, bits[i], 32'h31);
      end
      $display("Test src done");
   endtask : t_src
   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end
   initial begin
      i_reset = 1'b1;
      {i_psel, i_penable, i_pwrite, i_stop_req, i_stop2_sel} = '0;
      {i_por_detect, i_below_low_thresh, i_below_high_thresh} = '0;
      i_below_warn_thresh = 1'b0;
      i_paddr = 8'h00;
      i_pwdata = 32'h0;
      i_src = '0;
      i_irq_pending = '0;
      n_errors = 0;
      compares = 0;
      repeat (20) @(posedge i_clk);
      i_reset <= 1'b0;
      t_init();
      t_por();
      t_lv();
      t_stop();
      t_vec();
      t_src();
      conclude();
   end
endmodule : lvrc_top_tb
